// File: interrupt_vectoring_latency.sv
// Interrupt arbiter and vector generator with Avalon-MM register slave
//
// Implementation choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module interrupt_vectoring_latency
  import irq_vec_pkg::*;
#(
  parameter int unsigned SOURCES = NUM_SRC
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        extPinIrqA_n,
  input  wire logic        extPinIrqB_n,
  input  wire logic [21:0] periphEvent,
  input  wire logic        supplyWarning,
  input  wire logic        portMatch,
  input  wire logic        instrEnd,
  input  wire logic        retiEnd,
  output logic             callReq,
  output logic      [15:0] callVector,
  output logic             callHigh,
  output logic             serviceHigh,
  output logic             serviceLow,
  output logic             irq
);

  initial
  begin
    if (SOURCES != NUM_SRC)
    begin
      $error("source count is fixed by the vector table");
    end
  end

  // Lowest set order number, with a found flag on top
  function automatic logic [5:0] pickLowest(input logic [21:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  // Vector address for an order number
  function automatic logic [15:0] vectorOf(input logic [4:0] ord);
    return VECTOR_BASE + 16'({11'h000, ord} * VECTOR_STEP);
  endfunction

  // One-hot of an order number
  function automatic logic [21:0] oneHot(input logic [4:0] ord);
    return 22'h000001 << ord;
  endfunction

  // Reset release through two flip-flops
  logic [1:0] rstSyncReg;
  wire  logic rstN = rstSyncReg[1];

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      rstSyncReg <= 2'b00;
    else
      rstSyncReg <= {rstSyncReg[0], 1'b1};
  end

  // External pin edges
  logic extAFall;
  logic extBFall;

  ext_pin_edge #(.STAGES(2)) uPinA (
    .clk       (ref_clk),
    .rstN      (rstN),
    .pin_n     (extPinIrqA_n),
    .fallPulse (extAFall)
  );

  ext_pin_edge #(.STAGES(2)) uPinB (
    .clk       (ref_clk),
    .rstN      (rstN),
    .pin_n     (extPinIrqB_n),
    .fallPulse (extBFall)
  );

  // State registers
  logic [7:0]          coreEnReg;
  logic [14:0]         extEnReg;
  logic [6:0]          corePriReg;
  logic [14:0]         extPriReg;
  logic [21:0]         pendReg;
  logic [21:0]         reqReg;
  logic [STATUS_W-1:0] statusReg;
  logic [STATUS_W-1:0] maskReg;
  logic [7:0]          rtcIndexReg;
  logic                servHighReg;
  logic                servLowReg;
  logic                bootReg;
  logic [2:0]          callCntReg;
  logic                waitReg;

  // Bus decode
  wire logic        busReq     = avs_read | avs_write;
  wire logic        wrAccept   = avs_write & ~waitReg;
  wire logic [31:0] beMask     = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire logic        selCoreEn  = avs_address == OFF_CORE_EN;
  wire logic        selExtEn   = avs_address == OFF_EXT_EN;
  wire logic        selCorePri = avs_address == OFF_CORE_PRI;
  wire logic        selExtPri  = avs_address == OFF_EXT_PRI;
  wire logic        selPend    = avs_address == OFF_PENDING;
  wire logic        selStatus  = avs_address == OFF_STATUS;
  wire logic        selMask    = avs_address == OFF_MASK;
  wire logic        selActive  = avs_address == OFF_ACTIVE;
  wire logic        selRtcIdx  = avs_address == OFF_RTC_INDEX;
  wire logic        selRtcData = avs_address == OFF_RTC_DATA;
  wire logic        rtcAtFlags = rtcIndexReg == RTC_FLAG_INDEX;

  // Pending view: latched flags plus level-driven sources
  wire logic [21:0] levelBits  = oneHot(5'(SRC_SUPPLY)) & {22{supplyWarning}};
  wire logic [21:0] matchBits  = oneHot(5'(SRC_PORT_MATCH)) & {22{portMatch}};
  wire logic [21:0] pendView   = (pendReg & ~LEVEL_MASK) | levelBits | matchBits;
  wire logic [31:0] rtcRead    = rtcAtFlags ? {30'h0, pendReg[SRC_RTC_OSC], pendReg[SRC_RTC_ALARM]} : 32'h0;
  wire logic [21:0] pendDirect = pendView & ~(oneHot(5'(SRC_RTC_ALARM)) | oneHot(5'(SRC_RTC_OSC)));

  // Read multiplexer, unmapped reads as zero
  wire logic [31:0] readMux =
      selCoreEn  ? {24'h0, coreEnReg} :
      selExtEn   ? {17'h0, extEnReg} :
      selCorePri ? {24'h0, PRI_UNUSED_ONE | {1'b0, corePriReg}} :
      selExtPri  ? {17'h0, extPriReg} :
      selPend    ? {10'h0, pendDirect} :
      selStatus  ? {29'h0, statusReg} :
      selMask    ? {29'h0, maskReg} :
      selActive  ? {14'h0, servHighReg, servLowReg, callVector} :
      selRtcIdx  ? {24'h0, rtcIndexReg} :
      selRtcData ? rtcRead : 32'h0;

  // Byte-lane merge for plain writes
  wire logic [31:0] merged     = (readMux & ~beMask) | (avs_writedata & beMask);
  wire logic [31:0] w1cData    = avs_writedata & beMask;

  // enable and priority vectors by order position
  wire logic [21:0] enVec      = {extEnReg, coreEnReg[CORE_SRC_W-1:0]};
  wire logic [21:0] priVec     = {extPriReg, corePriReg};
  wire logic        globalEn   = coreEnReg[GLOBAL_EN_BIT];

  wire logic [21:0] reqNow     = pendView & enVec & {22{globalEn}} & ~RESERVED_MASK;

  // Arbitration on the detected requests
  wire logic [21:0] hiReq      = reqReg & priVec;
  wire logic [21:0] loReq      = reqReg & ~priVec;
  // lowest order wins within a level
  wire logic [5:0]  hiPick     = pickLowest(hiReq);
  wire logic [5:0]  loPick     = pickLowest(loReq);
  // high may preempt low, never the reverse
  wire logic        canHigh    = hiPick[5] & ~servHighReg;
  wire logic        canLow     = loPick[5] & ~servHighReg & ~servLowReg;
  wire logic [4:0]  winIdx     = canHigh ? hiPick[4:0] : loPick[4:0];

  // no vectoring at the return boundary itself
  wire logic        boundary   = instrEnd & ~retiEnd & (callCntReg == 3'h0);
  wire logic        doBoot     = bootReg & (callCntReg == 3'h0);
  // call issued at the instruction boundary
  wire logic        doVector   = boundary & (canHigh | canLow) & ~bootReg;
  wire logic        issue      = doBoot | doVector;
  wire logic [21:0] winHot     = oneHot(winIdx) & {22{doVector}};

  // Pending flag update terms
  wire logic [21:0] hwSet      = (periphEvent & EVENT_MASK)
                               | (oneHot(5'(SRC_EXT_A)) & {22{extAFall}})
                               | (oneHot(5'(SRC_EXT_B)) & {22{extBFall}});
  wire logic        pendWr     = wrAccept & selPend;
  // read-only flags excluded from software writes
  wire logic [21:0] swSet      = merged[21:0] & SW_WRITE_MASK & {22{pendWr}};
  wire logic [21:0] swClr      = ~merged[21:0] & SW_WRITE_MASK & {22{pendWr}};
  wire logic [21:0] hwClr      = winHot & HW_CLEAR_MASK;
  wire logic        rtcWr      = wrAccept & selRtcData & rtcAtFlags;
  wire logic [21:0] rtcClr     = (oneHot(5'(SRC_RTC_ALARM)) & {22{rtcWr & w1cData[RTC_ALARM_BIT]}})
                               | (oneHot(5'(SRC_RTC_OSC)) & {22{rtcWr & w1cData[RTC_OSC_BIT]}});
  // set regardless of enables, set beats clear
  wire logic [21:0] pendNext   = ((pendReg & ~(swClr | hwClr | rtcClr)) | swSet | hwSet)
                               & ~(RESERVED_MASK | LEVEL_MASK);

  // Event status update, set beats write-one clear
  wire logic [STATUS_W-1:0] stSet  = {retiEnd, doVector & canHigh & servLowReg, doVector};
  wire logic [STATUS_W-1:0] stClr  = w1cData[STATUS_W-1:0] & {STATUS_W{wrAccept & selStatus}};
  wire logic [STATUS_W-1:0] statusNext = (statusReg & ~stClr) | stSet;

  // Service level tracking
  wire logic        servHighNext = doVector & canHigh ? 1'b1 :
                                   retiEnd & servHighReg ? 1'b0 : servHighReg;
  wire logic        servLowNext  = doVector & ~canHigh ? 1'b1 :
                                   retiEnd & ~servHighReg ? 1'b0 : servLowReg;

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      reqReg <= 22'h000000;
    else
      reqReg <= reqNow;
  end

  // flags left set simply request again
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      pendReg <= PEND_RESET;
    else
      pendReg <= pendNext;
  end

  // Software-written configuration
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      coreEnReg   <= CORE_EN_RESET;
      extEnReg    <= EXT_RESET;
      corePriReg  <= CORE_PRI_RESET;
      extPriReg   <= EXT_RESET;
      maskReg     <= STATUS_RESET;
      rtcIndexReg <= 8'h00;
    end
    else if (wrAccept)
    begin
      if (selCoreEn)  coreEnReg   <= merged[7:0];
      if (selExtEn)   extEnReg    <= merged[14:0] & ~RESERVED_MASK[21:7];
      if (selCorePri) corePriReg  <= merged[6:0];
      if (selExtPri)  extPriReg   <= merged[14:0] & ~RESERVED_MASK[21:7];
      if (selMask)    maskReg     <= merged[STATUS_W-1:0];
      if (selRtcIdx)  rtcIndexReg <= merged[7:0];
    end
  end

  // Status and interrupt line
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      statusReg <= STATUS_RESET;
      irq       <= 1'b0;
    end
    else
    begin
      statusReg <= statusNext;
      irq       <= |(statusNext & maskReg);
    end
  end

  // service level flags, cleared by return
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      servHighReg <= 1'b0;
      servLowReg  <= 1'b0;
    end
    else
    begin
      servHighReg <= servHighNext;
      servLowReg  <= servLowNext;
    end
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      callCntReg <= 3'h0;
    else if (issue)
      callCntReg <= LCALL_COUNT;
    else if (callCntReg != 3'h0)
      callCntReg <= callCntReg - 3'h1;
  end

  // reset vector issued once after release
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      bootReg <= 1'b1;
    else if (doBoot)
      bootReg <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      callReq    <= 1'b0;
      callVector <= RESET_VECTOR;
      callHigh   <= 1'b0;
    end
    else
    begin
      callReq <= issue;
      if (issue)
      begin
        callVector <= doBoot ? RESET_VECTOR : vectorOf(winIdx);
        callHigh   <= doBoot | canHigh;
      end
    end
  end

  // Service level outputs mirror the flags
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      serviceHigh <= 1'b0;
      serviceLow  <= 1'b0;
    end
    else
    begin
      serviceHigh <= servHighNext;
      serviceLow  <= servLowNext;
    end
  end

  // Avalon slave: one wait state, data latched on the first cycle
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      waitReg      <= 1'b1;
      avs_readdata <= 32'h0;
    end
    else
    begin
      waitReg <= ~(busReq & waitReg);
      if (avs_read & waitReg)
        avs_readdata <= readMux;
    end
  end

  assign avs_waitrequest = waitReg;

endmodule // interrupt_vectoring_latency

// File: irq_vec_pkg.sv
// Shared constants for the interrupt arbitration and vectoring block
package irq_vec_pkg;

  // Source count and order numbers
  localparam int unsigned NUM_SRC        = 22;
  localparam int unsigned ORD_W          = 5;
  localparam int unsigned SRC_EXT_A      = 0;
  localparam int unsigned SRC_TMR_A      = 1;
  localparam int unsigned SRC_EXT_B      = 2;
  localparam int unsigned SRC_TMR_B      = 3;
  localparam int unsigned SRC_RTC_ALARM  = 8;
  localparam int unsigned SRC_CONV_DONE  = 10;
  localparam int unsigned SRC_SUPPLY     = 15;
  localparam int unsigned SRC_PORT_MATCH = 16;
  localparam int unsigned SRC_RTC_OSC    = 17;

  // Source class masks, one bit per order number
  localparam logic [21:0] RESERVED_MASK  = 22'h042000;
  localparam logic [21:0] HW_CLEAR_MASK  = 22'h00000F;
  localparam logic [21:0] SW_WRITE_MASK  = 22'h385EFF;
  localparam logic [21:0] EVENT_MASK     = 22'h3A5FFA;
  localparam logic [21:0] LEVEL_MASK     = 22'h018000;
  localparam logic [21:0] PEND_RESET     = 22'h000000;

  // Vector arithmetic
  localparam logic [15:0] RESET_VECTOR   = 16'h0000;
  localparam logic [15:0] VECTOR_BASE    = 16'h0003;
  localparam logic [15:0] VECTOR_STEP    = 16'h0008;

  // Response timing in system clocks
  localparam int unsigned DETECT_CYCLES  = 1;
  localparam int unsigned SINGLE_CYCLES  = 1;
  localparam int unsigned LCALL_CYCLES   = 5;
  localparam int unsigned RETI_CYCLES    = 5;
  localparam int unsigned DIV_CYCLES     = 8;
  localparam int unsigned BEST_CASE_CYCLES  = DETECT_CYCLES + SINGLE_CYCLES + LCALL_CYCLES;
  localparam int unsigned WORST_CASE_CYCLES = DETECT_CYCLES + RETI_CYCLES + DIV_CYCLES + LCALL_CYCLES;
  localparam logic [2:0]  LCALL_COUNT    = 3'(LCALL_CYCLES);

  // Register byte offsets
  localparam logic [5:0]  OFF_CORE_EN    = 6'h00;
  localparam logic [5:0]  OFF_EXT_EN     = 6'h04;
  localparam logic [5:0]  OFF_CORE_PRI   = 6'h08;
  localparam logic [5:0]  OFF_EXT_PRI    = 6'h0C;
  localparam logic [5:0]  OFF_PENDING    = 6'h10;
  localparam logic [5:0]  OFF_STATUS     = 6'h14;
  localparam logic [5:0]  OFF_MASK       = 6'h18;
  localparam logic [5:0]  OFF_ACTIVE     = 6'h1C;
  localparam logic [5:0]  OFF_RTC_INDEX  = 6'h20;
  localparam logic [5:0]  OFF_RTC_DATA   = 6'h24;

  // Register fields and reset values
  localparam int unsigned GLOBAL_EN_BIT  = 7;
  localparam int unsigned CORE_SRC_W     = 7;
  localparam int unsigned EXT_SRC_W      = 15;
  localparam logic [7:0]  CORE_EN_RESET  = 8'h00;
  localparam logic [6:0]  CORE_PRI_RESET = 7'h00;
  localparam logic [14:0] EXT_RESET      = 15'h0000;
  localparam logic [7:0]  PRI_UNUSED_ONE = 8'h80;
  localparam int unsigned ACT_LOW_BIT    = 16;
  localparam int unsigned ACT_HIGH_BIT   = 17;
  localparam logic [7:0]  RTC_FLAG_INDEX = 8'h00;
  localparam int unsigned RTC_ALARM_BIT  = 0;
  localparam int unsigned RTC_OSC_BIT    = 1;

  // Event status bits
  localparam int unsigned STATUS_W       = 3;
  localparam int unsigned ST_CALL        = 0;
  localparam int unsigned ST_PREEMPT     = 1;
  localparam int unsigned ST_RETURN      = 2;
  localparam logic [2:0]  STATUS_RESET   = 3'h0;

endpackage

// File: ext_pin_edge.sv
// Pin synchroniser with falling-edge pulse for the external interrupt pins
`timescale 1ns/1ps
module ext_pin_edge #(
  parameter int unsigned STAGES = 2
) (
  input  wire logic clk,
  input  wire logic rstN,
  input  wire logic pin_n,
  output logic      fallPulse
);

  initial
  begin
    if (STAGES < 2)
    begin
      $error("ext_pin_edge needs at least two synchroniser stages");
    end
  end

  logic [STAGES-1:0] syncReg;
  logic              prevReg;
  wire  logic        syncOut = syncReg[STAGES-1];

  // Synchroniser chain, idle level high
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      syncReg   <= '1;
      prevReg   <= 1'b1;
      fallPulse <= 1'b0;
    end
    else
    begin
      syncReg   <= {syncReg[STAGES-2:0], pin_n};
      prevReg   <= syncOut;
      fallPulse <= prevReg & ~syncOut;
    end
  end

endmodule // ext_pin_edge

// File: interrupt_vectoring_latency_assertions.sv
// Port-level checks for the interrupt arbiter and vector generator
`timescale 1ns/1ps
module irq_vec_checker (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        instrEnd,
  input wire logic        retiEnd,
  input wire logic        callReq,
  input wire logic [15:0] callVector,
  input wire logic        callHigh,
  input wire logic        serviceHigh,
  input wire logic        serviceLow
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // Call issue timing and vector shape
  chk_call_spacing: assert property (callReq |=> !callReq [*4])
    else $error("second call inside the long call window");
  chk_call_cause: assert property ((callReq && callVector != 16'h0000) |-> $past(instrEnd) && !$past(retiEnd))
    else $error("call not preceded by a plain instruction end");
  chk_vector_form: assert property ((callReq && callVector != 16'h0000) |-> callVector[2:0] == 3'h3 && callVector <= 16'h00AB)
    else $error("vector outside base plus eight times order");
  chk_no_reserved: assert property (callReq |-> callVector != 16'h006B && callVector != 16'h0093)
    else $error("reserved vector slot selected");

  // Level bookkeeping and preemption
  chk_high_held: assert property (serviceHigh |=> !callReq)
    else $error("high level routine was preempted");
  chk_low_block: assert property ((callReq && $past(serviceLow) && !$past(serviceHigh)) |-> callHigh)
    else $error("low call issued while low routine active");
  chk_call_marks: assert property ((callReq && callVector != 16'h0000) |-> (callHigh ? serviceHigh : serviceLow))
    else $error("active level does not follow the call level");
  chk_reti_drop: assert property ((retiEnd && serviceHigh) |=> !serviceHigh)
    else $error("return did not end the high routine");

  // Register bus answer
  chk_bus_answer: assert property ($rose(avs_read || avs_write) |-> ##[1:3] !avs_waitrequest)
    else $error("bus request not answered in time");
  chk_one_wait: assert property (((avs_read || avs_write) && !avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  // Main scenarios
  cover property (callReq && callHigh && serviceLow);
  cover property (retiEnd ##2 callReq);
  cover property (callReq && callVector == 16'h0053);
endmodule // irq_vec_checker

bind interrupt_vectoring_latency irq_vec_checker checkInst (
  .ref_clk(ref_clk), .nrst(nrst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .instrEnd(instrEnd), .retiEnd(retiEnd), .callReq(callReq),
  .callVector(callVector), .callHigh(callHigh), .serviceHigh(serviceHigh), .serviceLow(serviceLow)
);

// File: cpu_seq_model.sv
// Behavioural instruction sequencer facing the vectoring block
`timescale 1ns/1ps
module cpu_seq_model (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       callReq,
  input  wire logic       retiCmd,
  input  wire logic [3:0] instrLen,
  output logic            instrEnd,
  output logic            retiEnd
);
  logic [3:0] cnt;
  logic       isReti;
  logic       isCall;
  logic       retiWant;

  assign instrEnd = (cnt == 4'h1) && !isCall;
  assign retiEnd  = instrEnd && isReti;

  // Instruction, return and call sequencing
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt      <= 4'h0;
      isReti   <= 1'b0;
      isCall   <= 1'b0;
      retiWant <= 1'b0;
    end
    else
    begin
      if (retiCmd)
        retiWant <= 1'b1;
      if (callReq)
      begin
        cnt    <= 4'h5;
        isCall <= 1'b1;
        isReti <= 1'b0;
      end
      else if (cnt <= 4'h1)
      begin
        isCall <= 1'b0;
        if (retiWant || retiCmd)
        begin
          cnt      <= 4'h5;
          isReti   <= 1'b1;
          retiWant <= 1'b0;
        end
        else
        begin
          cnt    <= instrLen;
          isReti <= 1'b0;
        end
      end
      else
        cnt <= cnt - 4'h1;
    end
  end
endmodule // cpu_seq_model

// File: testbench.sv
// Self-checking bench for the interrupt arbiter and vector generator
`timescale 1ns/1ps
module testbench
  import irq_vec_pkg::*;
;
  localparam int LIMIT = 4000;
  logic        ref_clk       = 1'b0;
  logic        nrst          = 1'b0;
  logic [5:0]  avs_address   = 6'h00;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic        extPinIrqA_n  = 1'b1;
  logic        supplyWarning = 1'b0;
  logic        portMatch     = 1'b0;
  logic [21:0] periphEvent   = 22'h0;
  logic        retiCmd       = 1'b0;
  logic [3:0]  instrLen      = 4'h1;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        instrEnd, retiEnd, callReq, callHigh, serviceHigh, serviceLow, irq;
  logic [15:0] callVector;
  logic [31:0] rdat;
  int          failures = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          callCount = 0;
  int          t0 = 0;

  interrupt_vectoring_latency uut (
    .ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .extPinIrqA_n(extPinIrqA_n),
    .extPinIrqB_n(1'b1), .periphEvent(periphEvent), .supplyWarning(supplyWarning), .portMatch(portMatch),
    .instrEnd(instrEnd), .retiEnd(retiEnd), .callReq(callReq), .callVector(callVector),
    .callHigh(callHigh), .serviceHigh(serviceHigh), .serviceLow(serviceLow), .irq(irq)
  );
  cpu_seq_model seqModel (
    .clk(ref_clk), .nrst(nrst), .callReq(callReq), .retiCmd(retiCmd),
    .instrLen(instrLen), .instrEnd(instrEnd), .retiEnd(retiEnd)
  );

  // Clock, cycle count, call count and hang limit
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc++;
    if (callReq === 1'b1)
      callCount++;
    if (cyc == LIMIT)
    begin
      failures++;
      test_done();
    end
  end

  task automatic test_done();
    if (failures == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus cycle, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_read      <= !wr;
    avs_write     <= wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge ref_clk);
    rdat = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rdat, exp);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd);
  endtask

  task automatic pulse(input logic [21:0] bits);
    periphEvent <= bits;
    @(negedge ref_clk);
    t0 = cyc;
    @(posedge ref_clk);
    periphEvent <= 22'h0;
  endtask

  // Wait for a call, then compare vector, level and latency
  task automatic wait_call(input logic [15:0] vec, input logic hi, input int lat);
    int g;
    g = 0;
    do
    begin
      @(negedge ref_clk);
      g++;
    end
    while (callReq !== 1'b1 && g < 60);
    if (lat >= 0)
      check(32'(cyc - t0), 32'(lat));
    check({16'h0, callVector}, {16'h0, vec});
    check({31'h0, callHigh}, {31'h0, hi});
    @(posedge ref_clk);
  endtask

  task automatic reti(input logic [3:0] len);
    int g;
    g = 0;
    instrLen <= len;
    retiCmd  <= 1'b1;
    @(posedge ref_clk);
    retiCmd <= 1'b0;
    do
    begin
      @(negedge ref_clk);
      g++;
    end
    while (retiEnd !== 1'b1 && g < 80);
    t0 = cyc;
    @(posedge ref_clk);
  endtask

  task automatic idle_nocall(input int n);
    int c;
    c = callCount;
    repeat (n) @(posedge ref_clk);
    check(32'(callCount), 32'(c));
  endtask

  // Main sequence
  initial
  begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    wait_call(RESET_VECTOR, 1'b1, -1);
    rd_chk(OFF_CORE_PRI, 32'h80);
    rd_chk(OFF_CORE_EN, 32'h0);
    rd_chk(6'h28, 32'h0);
    wr(OFF_CORE_EN, 32'h8B);
    wr(OFF_EXT_EN, 32'h8);
    wr(OFF_CORE_PRI, 32'h2);
    extPinIrqA_n <= 1'b0;
    wait_call(16'h0003, 1'b0, -1);
    extPinIrqA_n <= 1'b1;
    rd_chk(OFF_PENDING, 32'h0);
    reti(4'h1);
    idle_nocall(10);
    wr(OFF_STATUS, 32'h7);
    wr(OFF_MASK, 32'h7);
    pulse(22'h000400);
    wait_call(16'h0053, 1'b0, 3);
    check({31'h0, serviceLow}, 32'h1);
    pulse(22'h00000A);
    wait_call(16'h000B, 1'b1, -1);
    rd_chk(OFF_PENDING, 32'h408);
    rd_chk(OFF_STATUS, 32'h3);
    check({31'h0, irq}, 32'h1);
    wr(OFF_STATUS, 32'h3);
    rd_chk(OFF_STATUS, 32'h0);
    check({31'h0, irq}, 32'h0);
    reti(4'h1);
    idle_nocall(12);
    reti(4'h1);
    wait_call(16'h001B, 1'b0, 2);
    rd_chk(OFF_PENDING, 32'h400);
    reti(4'h8);
    wait_call(16'h0053, 1'b0, 9);
    supplyWarning <= 1'b1;
    portMatch     <= 1'b1;
    rd_chk(OFF_PENDING, 32'h18400);
    wr(OFF_PENDING, 32'h0);
    rd_chk(OFF_PENDING, 32'h18000);
    reti(4'h1);
    idle_nocall(12);
    wr(OFF_EXT_EN, 32'h208);
    wait_call(16'h0083, 1'b0, -1);
    pulse(22'h000100);
    rd_chk(OFF_PENDING, 32'h18000);
    rd_chk(OFF_RTC_DATA, 32'h1);
    wr(OFF_RTC_DATA, 32'h1);
    rd_chk(OFF_RTC_DATA, 32'h0);
    test_done();
  end
endmodule // testbench
